/* logic/mcsr_pkg.sv */
// Constants, codes and carriers shared by the core special-register bank.
package mcsr_pkg;

  // Counter and return stack geometry.
  localparam int PC_W  = 10;
  localparam int STK_D = 5;

  // Data-memory offsets of the registers held here.
  localparam logic [5:0] A_IND_PORT = 6'h00;
  localparam logic [5:0] A_TMR      = 6'h01;
  localparam logic [5:0] A_PC_LOW   = 6'h02;
  localparam logic [5:0] A_STATUS   = 6'h03;
  localparam logic [5:0] A_IND_PTR  = 6'h04;
  localparam logic [5:0] A_PORT_A   = 6'h05;
  localparam logic [5:0] A_PORT_B   = 6'h06;
  localparam logic [5:0] A_GPR7     = 6'h07;
  localparam logic [5:0] A_PWR_CTL  = 6'h08;
  localparam logic [5:0] A_WAKE     = 6'h09;
  localparam logic [5:0] A_HIBUF    = 6'h0a;
  localparam logic [5:0] A_GPR_LO   = 6'h10;

  // Status bit positions.
  localparam int ST_C   = 0;
  localparam int ST_HC  = 1;
  localparam int ST_Z   = 2;
  localparam int ST_PWD = 3;
  localparam int ST_TMO = 4;

  // Power control bit positions.
  localparam int PW_WDOG     = 7;
  localparam int PW_INT_ROLE = 6;
  localparam int PW_LVD      = 5;
  localparam int PW_RES_OPT  = 4;

  // Reset values.
  localparam logic [PC_W-1:0] RST_PC   = 10'h3ff;
  localparam logic [7:0]      RST_STAT = 8'h18;
  localparam logic [7:0]      RST_POWER_CONTROL = 8'h00;
  localparam logic [7:0]      RST_WAKE = 8'h00;
  localparam logic [7:0]      PTR_TOP  = 8'hc0;

  // Program counter actions, one-hot.
  typedef enum logic [4:0] {
    PC_HOLD = 5'h01,
    PC_STEP = 5'h02,
    PC_JUMP = 5'h04,
    PC_CALL = 5'h08,
    PC_RET  = 5'h10
  } mcsr_pcop_e;

  // Flag-affecting ALU operation classes, one-hot.
  typedef enum logic [5:0] {
    ALU_NONE  = 6'h01,
    ALU_ADD   = 6'h02,
    ALU_SUB   = 6'h04,
    ALU_RRC   = 6'h08,
    ALU_RLC   = 6'h10,
    ALU_LOGIC = 6'h20
  } mcsr_aluop_e;

  // One register-file access from the core.
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [5:0] addr;
    logic [7:0] wdata;
  } mcsr_req_s;

  // Operands of the flag-affecting operation.
  typedef struct packed {
    mcsr_aluop_e op;
    logic [7:0]  a;
    logic [7:0]  b;
  } mcsr_alu_s;

  // Timer hooks held in the write-only option register.
  typedef struct packed {
    logic timer_source_select;
    logic timer_edge_select;
    logic prescaler_assign;
  } mcsr_opt_s;

endpackage : mcsr_pkg

/* logic/mcsr_regs.sv */
// Low special-function register bank of the 8-bit accumulator core.
`timescale 1ns/10ps
module mcsr_regs
  import mcsr_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     step,
  input  wire mcsr_pkg::mcsr_req_s      req,
  input  wire mcsr_pkg::mcsr_alu_s      alu,
  input  wire mcsr_pkg::mcsr_pcop_e     pc_op,
  input  wire logic [mcsr_pkg::PC_W-1:0] pc_target,
  input  wire mcsr_pkg::mcsr_opt_s      opt,
  input  wire logic                     timer_external_clock_pin,
  input  wire logic                     tof_clr,
  input  wire logic                     watchdog_clear_instruction,
  input  wire logic                     sleep_ins,
  input  wire logic                     wdt_overflow,
  input  wire logic [7:0]               pin_a,
  input  wire logic [7:0]               pin_b,
  output logic [7:0]                    rd_data,
  output logic [mcsr_pkg::PC_W-1:0]     pc,
  output logic [7:0]                    status_flags,
  output logic [7:0]                    port_a_data,
  output logic [7:0]                    port_b_data,
  output logic [7:0]                    power_control,
  output logic [7:0]                    wake_en,
  output logic                          ext_int_path,
  output logic [7:0]                    timer_count,
  output logic                          tmr_ovf,
  output logic                          timer_overflow_flag,
  output logic                          presc_clr
);
  import mcsr_pkg::*;

  // Effective address decode, shared by the read and write paths.
  function automatic logic [5:0] mcsr_ea(input logic [5:0] a, input logic [7:0] f);
    return (a == A_IND_PORT) ? f[5:0] : a;
  endfunction : mcsr_ea

  // True for locations that are plain storage.
  function automatic logic mcsr_is_gpr(input logic [5:0] a);
    return (a == A_GPR7) || (a >= A_GPR_LO);
  endfunction : mcsr_is_gpr

  logic [7:0]      ind_ptr;              // Indirect pointer, top bits held at one.
  logic [1:0]      high_bits_buffer;     // Staging for counter bits 9..8.
  logic [7:0]      gpr [0:63];           // Storage for general locations.
  logic [PC_W-1:0] stk [0:STK_D-1];      // Return stack entries.
  logic [2:0]      sp;                   // Next free stack slot.
  logic [2:0]      sp_top;               // Slot holding the top entry.
  logic [5:0]      ea;                   // Effective address of this access.
  logic            wr_ok;                // Write allowed to land.
  logic [7:0]      next_rd;              // Read mux result.
  logic            pin_q;                // Previous timer pin level.
  logic            tmr_inc;              // Timer source event.
  logic            upd_c;                // Carry owned by flag logic.
  logic            upd_dc;               // Half carry owned by flag logic.
  logic            upd_z;                // Zero owned by flag logic.
  logic            nc;                   // New carry.
  logic            ndc;                  // New half carry.
  logic            nz;                   // New zero.
  logic [8:0]      sum9;                 // Full-width add for carry.
  logic [4:0]      sum5;                 // Low nibble add for half carry.

  // The pointer substitutes for location zero; a write that still lands
  // on location zero is dropped since there is no storage behind it.
  assign ea    = mcsr_ea(req.addr, ind_ptr);
  assign wr_ok = req.wr && (ea != A_IND_PORT);

  // Top entry sits one below the free slot, wrapping round the ring.
  assign sp_top = (sp == 3'h0) ? 3'(STK_D - 1) : sp - 3'h1;

  // Pin events are plain synchronous inputs; only edge memory is kept.
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= timer_external_clock_pin;
    end
  end

  // Source choice: the instruction clock or one chosen pin edge.
  always_comb begin
    if (opt.timer_source_select) begin
      if (opt.timer_edge_select) begin
        tmr_inc = pin_q && !timer_external_clock_pin;
      end else begin
        tmr_inc = !pin_q && timer_external_clock_pin;
      end
    end else begin
      tmr_inc = step;
    end
  end

  // Timer count; a software write wins over a count in the same cycle.
  always_ff @(posedge clk) begin
    if (rst) begin
      timer_count <= 8'h00;
      tmr_ovf     <= 1'b0;
      presc_clr   <= 1'b0;
    end else begin
      tmr_ovf   <= 1'b0;
      presc_clr <= 1'b0;
      if (wr_ok && ea == A_TMR) begin
        timer_count <= req.wdata;
        presc_clr   <= !opt.prescaler_assign;
      end else if (tmr_inc) begin
        timer_count <= timer_count + 8'h01;
        tmr_ovf     <= (timer_count == 8'hff);
      end
    end
  end

  // Overflow flag; a new overflow wins over a clear in the same cycle.
  always_ff @(posedge clk) begin
    if (rst) begin
      timer_overflow_flag <= 1'b0;
    end else if (tmr_ovf) begin
      timer_overflow_flag <= 1'b1;
    end else if (tof_clr) begin
      timer_overflow_flag <= 1'b0;
    end
  end

  // Flag results for the operation classes that touch zero, half carry and carry.
  // Subtraction adds the two's complement, so carry out means no borrow.
  always_comb begin
    sum9   = 9'h000;
    sum5   = 5'h00;
    upd_c  = 1'b0;
    upd_dc = 1'b0;
    upd_z  = 1'b0;
    nc     = 1'b0;
    ndc    = 1'b0;
    nz     = 1'b0;
    case (alu.op)
      ALU_ADD: begin
        sum9   = {1'b0, alu.a} + {1'b0, alu.b};
        sum5   = {1'b0, alu.a[3:0]} + {1'b0, alu.b[3:0]};
        upd_c  = 1'b1;
        upd_dc = 1'b1;
        upd_z  = 1'b1;
        nc     = sum9[8];
        ndc    = sum5[4];
        nz     = (sum9[7:0] == 8'h00);
      end
      ALU_SUB: begin
        sum9   = {1'b0, alu.a} + {1'b0, ~alu.b} + 9'h001;
        sum5   = {1'b0, alu.a[3:0]} + {1'b0, ~alu.b[3:0]} + 5'h01;
        upd_c  = 1'b1;
        upd_dc = 1'b1;
        upd_z  = 1'b1;
        nc     = sum9[8];
        ndc    = sum5[4];
        nz     = (sum9[7:0] == 8'h00);
      end
      ALU_RRC: begin
        upd_c = 1'b1;
        nc    = alu.a[0];
      end
      ALU_RLC: begin
        upd_c = 1'b1;
        nc    = alu.a[7];
      end
      ALU_LOGIC: begin
        upd_z = 1'b1;
        nz    = (alu.a == 8'h00);
      end
      default: begin
        upd_c = 1'b0;
      end
    endcase
  end

  // Status: while any flag operation runs, a write leaves all three low
  // flags alone, so flags the operation does not touch keep their value.
  always_ff @(posedge clk) begin
    if (rst) begin
      status_flags <= RST_STAT;
    end else begin
      if (wr_ok && ea == A_STATUS) begin
        status_flags[7:5] <= req.wdata[7:5];
        if (!(upd_c || upd_dc || upd_z)) begin
          status_flags[2:0] <= req.wdata[2:0];
        end
      end
      if (upd_c) begin
        status_flags[ST_C] <= nc;
      end
      if (upd_dc) begin
        status_flags[ST_HC] <= ndc;
      end
      if (upd_z) begin
        status_flags[ST_Z] <= nz;
      end
      // Set events win if they coincide with a clearing one.
      if (watchdog_clear_instruction) begin
        status_flags[ST_PWD] <= 1'b1;
      end else if (sleep_ins) begin
        status_flags[ST_PWD] <= 1'b0;
      end
      if (watchdog_clear_instruction || sleep_ins) begin
        status_flags[ST_TMO] <= 1'b1;
      end else if (wdt_overflow) begin
        status_flags[ST_TMO] <= 1'b0;
      end
    end
  end

  // Pointer, latches, power control and the high buffer.
  always_ff @(posedge clk) begin
    if (rst) begin
      ind_ptr          <= PTR_TOP;
      port_a_data      <= 8'h00;
      port_b_data      <= 8'h00;
      power_control    <= RST_POWER_CONTROL;
      high_bits_buffer <= 2'b00;
    end else if (wr_ok) begin
      case (ea)
        A_IND_PTR: ind_ptr <= PTR_TOP | req.wdata;
        A_PORT_A:  port_a_data <= req.wdata;
        A_PORT_B:  port_b_data <= req.wdata;
        A_PWR_CTL: power_control <= {req.wdata[7:4], 4'h0};
        A_HIBUF:   high_bits_buffer <= req.wdata[1:0];
        default:   ind_ptr <= ind_ptr;
      endcase
    end
  end

  // Wake enables as seen by the change detector, pin zero masked in the
  // interrupt role; the output is a second flop fed from the software copy, one cycle behind it.
  logic [7:0] wake_reg;                  // Software copy of the wake enables.
  always_ff @(posedge clk) begin
    if (rst) begin
      wake_reg     <= RST_WAKE;
      wake_en      <= RST_WAKE;
      ext_int_path <= 1'b0;
    end else begin
      if (wr_ok && ea == A_WAKE) begin
        wake_reg <= req.wdata;
      end
      wake_en      <= wake_reg & ~{7'h00, power_control[PW_INT_ROLE]};
      ext_int_path <= power_control[PW_INT_ROLE];
    end
  end

  // Plain storage has no reset; software initialises it.
  always_ff @(posedge clk) begin
    if (wr_ok && mcsr_is_gpr(ea)) begin
      gpr[ea] <= req.wdata;
    end
  end

  // Counter and stack. Branches beat a low-byte write, which beats a step.
  always_ff @(posedge clk) begin
    if (rst) begin
      pc <= RST_PC;
      sp <= 3'h0;
    end else begin
      case (pc_op)
        PC_JUMP: pc <= pc_target;
        PC_CALL: begin
          stk[sp] <= pc;
          sp      <= (sp == 3'(STK_D - 1)) ? 3'h0 : sp + 3'h1;
          pc      <= pc_target;
        end
        PC_RET: begin
          pc <= stk[sp_top];
          sp <= sp_top;
        end
        PC_STEP: begin
          if (wr_ok && ea == A_PC_LOW) begin
            pc <= {high_bits_buffer, req.wdata};
          end else begin
            pc <= pc + 10'h001;
          end
        end
        default: begin
          if (wr_ok && ea == A_PC_LOW) begin
            pc <= {high_bits_buffer, req.wdata};
          end
        end
      endcase
    end
  end

  // Read mux; location zero reached through a zero pointer reads 00h.
  always_comb begin
    case (ea)
      A_IND_PORT: next_rd = 8'h00;
      A_TMR:      next_rd = timer_count;
      A_PC_LOW:   next_rd = pc[7:0];
      A_STATUS:   next_rd = status_flags;
      A_IND_PTR:  next_rd = ind_ptr | PTR_TOP;
      A_PORT_A:   next_rd = pin_a;
      A_PORT_B:   next_rd = pin_b;
      A_PWR_CTL:  next_rd = {power_control[7:4], 4'h0};
      A_WAKE:     next_rd = wake_reg;
      A_HIBUF:    next_rd = {6'h00, high_bits_buffer};
      default:    next_rd = mcsr_is_gpr(ea) ? gpr[ea] : 8'h00;
    endcase
  end

  // Read data is registered, valid the cycle after the request.
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_data <= 8'h00;
    end else if (req.rd) begin
      rd_data <= next_rd;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Call followed at once by return.
  sequence s_call_ret;
    (pc_op == PC_CALL) ##1 (pc_op == PC_RET);
  endsequence

  // Timer at its top value taking a count with no write.
  sequence s_tmr_top;
    (timer_count == 8'hff) && tmr_inc && !(wr_ok && ea == A_TMR);
  endsequence

  a_ind_zero_read: assert property (
    req.rd && req.addr == A_IND_PORT && ind_ptr[5:0] == 6'h00 |=> rd_data == 8'h00)
    else $error("indirect self read not zero");

  a_ptr_top_ones: assert property (
    req.rd && req.addr == A_IND_PTR |=> rd_data[7:6] == 2'b11)
    else $error("pointer top bits not one");

  a_jump_load: assert property (
    pc_op == PC_JUMP |=> pc == $past(pc_target) && $stable(high_bits_buffer))
    else $error("jump target not loaded");

  a_low_byte_write: assert property (
    (pc_op == PC_STEP || pc_op == PC_HOLD) && req.wr &&
    mcsr_ea(req.addr, ind_ptr) == A_PC_LOW
    |=> pc == {$past(high_bits_buffer), $past(req.wdata)})
    else $error("low byte write misloaded");

  a_call_ret: assert property (
    s_call_ret |=> pc == $past(pc, 2))
    else $error("return did not restore pushed address");

  a_tmr_wrap: assert property (
    s_tmr_top |=> timer_count == 8'h00 && tmr_ovf ##1 !tmr_ovf)
    else $error("timer wrap missing");

  a_tof_sticky: assert property (
    tmr_ovf || (timer_overflow_flag && !tof_clr) |=> timer_overflow_flag)
    else $error("overflow flag not held");

  a_sleep_flags: assert property (
    sleep_ins && !watchdog_clear_instruction
    |=> !status_flags[ST_PWD] && status_flags[ST_TMO])
    else $error("sleep flags wrong");

  a_wake_mask: assert property (
    power_control[PW_INT_ROLE] |=> !wake_en[0] && ext_int_path)
    else $error("pin zero change path not masked");

  a_port_read: assert property (
    req.rd && mcsr_ea(req.addr, ind_ptr) == A_PORT_B |=> rd_data == $past(pin_b))
    else $error("port read not pin level");

endmodule : mcsr_regs

/* sim/mcsr_tb.sv */
// Self-checking testbench for the core special-register bank.
`timescale 1ns/10ps
module testbench
  import mcsr_pkg::*;
;
  logic                  clk;                          // Core clock, 8 ns period.
  logic                  rst;                          // Synchronous reset, active high.
  logic                  step;                         // Instruction-cycle strobe.
  mcsr_req_s             req;                          // Register access request.
  mcsr_alu_s             alu;                          // Flag operation of this cycle.
  mcsr_pcop_e            pc_op;                        // Counter action.
  logic [PC_W-1:0]       pc_target;                    // Jump and call target.
  mcsr_opt_s             opt;                          // Timer option bits.
  logic                  timer_external_clock_pin;     // Timer pin level.
  logic                  tof_clr;                      // Overflow flag clear pulse.
  logic                  watchdog_clear_instruction;   // Watchdog clear pulse.
  logic                  sleep_ins;                    // Sleep pulse.
  logic                  wdt_overflow;                 // Watchdog overflow pulse.
  logic [7:0]            pin_a;                        // Port A pin levels.
  logic [7:0]            pin_b;                        // Port B pin levels.
  logic [7:0]            rd_data;                      // Read data.
  logic [PC_W-1:0]       pc;                           // Program counter.
  logic [7:0]            status_flags;                 // Status register.
  logic [7:0]            port_a_data;                  // Port A latch.
  logic [7:0]            port_b_data;                  // Port B latch.
  logic [7:0]            power_control;                // Power control register.
  logic [7:0]            wake_en;                      // Effective wake enables.
  logic                  ext_int_path;                 // Interrupt role of pin zero.
  logic [7:0]            timer_count;                  // Timer value.
  logic                  tmr_ovf;                      // Overflow pulse.
  logic                  timer_overflow_flag;          // Sticky overflow flag.
  logic                  presc_clr;                    // Prescaler clear pulse.
  int                    n_mismatch;                   // Mismatches seen.
  int                    comparisons;                  // Comparisons made.
  logic                  pulse_seen;                   // Prescaler pulse after last write.

  mcsr_regs uut (
    .clk(clk), .rst(rst), .step(step), .req(req), .alu(alu), .pc_op(pc_op),
    .pc_target(pc_target), .opt(opt), .timer_external_clock_pin(timer_external_clock_pin),
    .tof_clr(tof_clr), .watchdog_clear_instruction(watchdog_clear_instruction),
    .sleep_ins(sleep_ins), .wdt_overflow(wdt_overflow), .pin_a(pin_a), .pin_b(pin_b),
    .rd_data(rd_data), .pc(pc), .status_flags(status_flags), .port_a_data(port_a_data),
    .port_b_data(port_b_data), .power_control(power_control), .wake_en(wake_en),
    .ext_int_path(ext_int_path), .timer_count(timer_count), .tmr_ovf(tmr_ovf),
    .timer_overflow_flag(timer_overflow_flag), .presc_clr(presc_clr)
  );

  // Free-running clock at 125 MHz.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done

  // Compares one byte-wide result; case equality keeps unknowns from matching.
  task automatic chk8(string name, logic [7:0] exp, logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk8

  // Compares a program counter value.
  task automatic chk10(string name, logic [9:0] exp, logic [9:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk10

  // One write; an extra idle cycle follows so two-stage results such as the wake enables have settled.
  task automatic wr(logic [5:0] a, logic [7:0] d);
    req = {1'b0, 1'b1, a, d};
    @(negedge clk);
    req = '0;
    pulse_seen = presc_clr;
    @(negedge clk);
  endtask : wr

  // One read, compared against the expected byte.
  task automatic rdchk(logic [5:0] a, logic [7:0] exp);
    req = {1'b1, 1'b0, a, 8'h00};
    @(negedge clk);
    req = '0;
    chk8($sformatf("read %h", a), exp, rd_data);
    @(negedge clk);
  endtask : rdchk

  // One counter action held for a single cycle.
  task automatic pc_do(mcsr_pcop_e op, logic [9:0] t);
    pc_op = op;
    pc_target = t;
    @(negedge clk);
    pc_op = PC_HOLD;
    @(negedge clk);
  endtask : pc_do

  // One flag operation held for a single cycle.
  task automatic alu_do(mcsr_aluop_e op, logic [7:0] a, logic [7:0] b);
    alu = {op, a, b};
    @(negedge clk);
    alu = {ALU_NONE, 8'h00, 8'h00};
    @(negedge clk);
  endtask : alu_do

  // Watchdog: the whole sequence needs well under a thousand cycles.
  initial begin
    #(8 * 5000);
    n_mismatch++;
    test_done();
  end

  // Main sequence; every input changes on the falling edge.
  initial begin
    n_mismatch = 0;
    comparisons = 0;
    pulse_seen = 1'b0;
    rst = 1'b1;
    step = 1'b0;
    req = '0;
    alu = {ALU_NONE, 8'h00, 8'h00};
    pc_op = PC_HOLD;
    pc_target = '0;
    opt = '0;
    timer_external_clock_pin = 1'b0;
    tof_clr = 1'b0;
    watchdog_clear_instruction = 1'b0;
    sleep_ins = 1'b0;
    wdt_overflow = 1'b0;
    pin_a = 8'h3c;
    pin_b = 8'ha5;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    chk10("pc reset", 10'h3ff, pc);
    chk8("status reset", 8'h18, status_flags);
    rdchk(A_IND_PTR, 8'hc0);
    // Indirect access, including the pointer-zero corner.
    wr(A_IND_PTR, 8'h10);
    wr(A_GPR_LO, 8'h12);
    rdchk(A_IND_PORT, 8'h12);
    wr(A_IND_PORT, 8'h34);
    rdchk(A_GPR_LO, 8'h34);
    wr(A_IND_PTR, 8'h06);
    rdchk(A_IND_PORT, 8'ha5);
    wr(A_IND_PTR, 8'h25);
    rdchk(A_IND_PTR, 8'he5);
    wr(A_IND_PTR, 8'h00);
    rdchk(A_IND_PORT, 8'h00);
    wr(A_IND_PORT, 8'h77);
    rdchk(A_IND_PTR, 8'hc0);
    rdchk(A_GPR_LO, 8'h34);
    wr(6'h0b, 8'hff);
    rdchk(6'h0b, 8'h00);
    // Ports read the pins, writes land in the latches.
    wr(A_PORT_B, 8'h5a);
    chk8("port b latch", 8'h5a, port_b_data);
    rdchk(A_PORT_B, 8'ha5);
    wr(A_PORT_A, 8'hc3);
    chk8("port a latch", 8'hc3, port_a_data);
    rdchk(A_PORT_A, 8'h3c);
    // Power control and the wake enables with the interrupt role on and off.
    wr(A_PWR_CTL, 8'hff);
    chk8("power control", 8'hf0, power_control);
    rdchk(A_PWR_CTL, 8'hf0);
    wr(A_WAKE, 8'hff);
    chk8("wake en masked", 8'hfe, wake_en);
    chk8("int path on", 8'h01, 8'(ext_int_path));
    rdchk(A_WAKE, 8'hff);
    wr(A_PWR_CTL, 8'h00);
    chk8("int path off", 8'h00, 8'(ext_int_path));
    chk8("wake en full", 8'hff, wake_en);
    wr(A_WAKE, 8'h5a);
    chk8("wake en bits", 8'h5a, wake_en);
    // Status: free bits, protected flags and flag logic winning over the write.
    wr(A_STATUS, 8'hff);
    chk8("status all", 8'hff, status_flags);
    alu = {ALU_LOGIC, 8'h00, 8'h00};
    wr(A_STATUS, 8'h00);
    alu = {ALU_NONE, 8'h00, 8'h00};
    chk8("status clear", 8'h1f, status_flags);
    sleep_ins = 1'b1;
    @(negedge clk);
    sleep_ins = 1'b0;
    chk8("after sleep", 8'h17, status_flags);
    wdt_overflow = 1'b1;
    @(negedge clk);
    wdt_overflow = 1'b0;
    chk8("after wdt ovf", 8'h07, status_flags);
    wr(A_STATUS, 8'h18);
    chk8("to pd locked", 8'h00, status_flags);
    watchdog_clear_instruction = 1'b1;
    @(negedge clk);
    watchdog_clear_instruction = 1'b0;
    chk8("after wdog clear", 8'h18, status_flags);
    // Flag arithmetic: low three bits are {Z, DC, C}.
    alu_do(ALU_ADD, 8'h0f, 8'h01);
    chk8("add half", 8'h02, 8'(status_flags[2:0]));
    alu_do(ALU_ADD, 8'hf0, 8'h10);
    chk8("add carry", 8'h05, 8'(status_flags[2:0]));
    alu_do(ALU_SUB, 8'h33, 8'h33);
    chk8("sub equal", 8'h07, 8'(status_flags[2:0]));
    alu_do(ALU_RLC, 8'h7f, 8'h00);
    chk8("rotate left", 8'h00, 8'(status_flags[0]));
    alu_do(ALU_RRC, 8'h01, 8'h00);
    chk8("rotate right", 8'h01, 8'(status_flags[0]));
    // Counter stepping, jump, and a full five-deep call chain.
    for (int i = 0; i < 3; i++) begin
      pc_do(PC_STEP, 10'h000);
    end
    chk10("pc step wrap", 10'h002, pc);
    pc_do(PC_JUMP, 10'h155);
    chk10("pc jump", 10'h155, pc);
    for (int i = 0; i < STK_D; i++) begin
      pc_do(PC_CALL, 10'h200 + 10'(i));
      chk10("pc call", 10'h200 + 10'(i), pc);
    end
    for (int i = STK_D - 1; i >= 0; i--) begin
      pc_do(PC_RET, 10'h000);
      chk10("pc return", (i == 0) ? 10'h155 : 10'h1ff + 10'(i), pc);
    end
    // A call answered at once by a return, with no idle cycle between.
    pc_op = PC_CALL;
    pc_target = 10'h2aa;
    @(negedge clk);
    pc_op = PC_RET;
    chk10("call target", 10'h2aa, pc);
    @(negedge clk);
    pc_op = PC_HOLD;
    chk10("call then return", 10'h155, pc);
    wr(A_HIBUF, 8'h02);
    wr(A_PC_LOW, 8'h34);
    chk10("low byte write", 10'h234, pc);
    pc_do(PC_JUMP, 10'h3cc);
    rdchk(A_PC_LOW, 8'hcc);
    rdchk(A_HIBUF, 8'h02);
    // Timer on instruction cycles, overflow and the sticky flag.
    wr(A_TMR, 8'hfe);
    chk8("presc clr", 8'h01, 8'(pulse_seen));
    step = 1'b1;
    @(negedge clk);
    step = 1'b0;
    @(negedge clk);
    chk8("timer step", 8'hff, timer_count);
    step = 1'b1;
    @(negedge clk);
    step = 1'b0;
    chk8("timer wrap", 8'h00, timer_count);
    chk8("ovf pulse", 8'h01, 8'(tmr_ovf));
    @(negedge clk);
    chk8("ovf single", 8'h00, 8'(tmr_ovf));
    chk8("ovf flag", 8'h01, 8'(timer_overflow_flag));
    repeat (3) @(negedge clk);
    chk8("ovf flag held", 8'h01, 8'(timer_overflow_flag));
    tof_clr = 1'b1;
    @(negedge clk);
    tof_clr = 1'b0;
    @(negedge clk);
    chk8("ovf flag clr", 8'h00, 8'(timer_overflow_flag));
    // Timer on pin edges: three rising, then three falling.
    opt = '{timer_source_select: 1'b1, timer_edge_select: 1'b0, prescaler_assign: 1'b1};
    wr(A_TMR, 8'h00);
    chk8("no presc clr", 8'h00, 8'(pulse_seen));
    for (int e = 0; e < 2; e++) begin
      opt.timer_edge_select = e[0];
      for (int i = 0; i < 3; i++) begin
        timer_external_clock_pin = 1'b1;
        repeat (2) @(negedge clk);
        timer_external_clock_pin = 1'b0;
        repeat (2) @(negedge clk);
      end
      chk8("pin edges", 8'(3 * (e + 1)), timer_count);
    end
    test_done();
  end
endmodule : testbench
